// >>> hdl/iss_params.svh
// constants of the i2c/spi slave control and status block
`ifndef ISS_PARAMS_SVH
`define ISS_PARAMS_SVH

// register byte addresses
`define ISS_OFS_DATA       8'h00
`define ISS_OFS_CONTROL    8'h04
`define ISS_OFS_FLAGS      8'h08
`define ISS_OFS_IRQ_LEVEL  8'h0c
`define ISS_OFS_OWN_ADDR   8'h10
`define ISS_OFS_SW_STATUS  8'h14
`define ISS_OFS_HOST_CTRL  8'h18

// reset values
`define ISS_CONTROL_RESET  7'h00
`define ISS_THR_RESET      3'h0
`define ISS_OWN_ADDR_RESET 7'h00
`define ISS_SW_STAT_RESET  4'h0
`define ISS_HOST_CTL_RESET 8'h00
`define ISS_SYNC_RESET     5'h1b

// fifo geometry
`define ISS_FIFO_DEPTH     16
`define ISS_PTR_W          4
`define ISS_FILL_W         5

// fill counts for threshold codes 000..100 on a 16-deep fifo
`define ISS_THR_CODE_8TH   3'h0
`define ISS_THR_CODE_4TH   3'h1
`define ISS_THR_CODE_HALF  3'h2
`define ISS_THR_CODE_3QTR  3'h3
`define ISS_THR_CODE_7TH   3'h4
`define ISS_THR_FILL_8TH   5'h02
`define ISS_THR_FILL_4TH   5'h04
`define ISS_THR_FILL_HALF  5'h08
`define ISS_THR_FILL_3QTR  5'h0c
`define ISS_THR_FILL_7TH   5'h0e

// byte sent when the transmit fifo runs dry
`define ISS_IDLE_BYTE      8'hff
`define ISS_BITS_PER_BYTE  4'h8
`define ISS_LAST_BIT       4'h7

`endif

// >>> hdl/iss_pkg.sv
// types of the i2c/spi slave control and status block
`default_nettype none
`include "iss_params.svh"
package iss_pkg;

  typedef logic [7:0] iss_byte_type;
  typedef logic [`ISS_FILL_W-1:0] iss_fill_type;

  typedef struct packed {
    logic host_control_byte_enable;
    logic host_status_byte_enable;
    logic spi_clk_polarity;
    logic spi_clk_phase;
    logic i2c_mode_enable;
    logic spi_mode_enable;
    logic device_enable;
  } iss_ctrl_type;

  typedef struct packed {
    iss_fill_type rx_fill_count;
    iss_fill_type tx_fill_count;
    logic         receive_in_progress;
    logic         tx_queue_empty;
    logic         rx_queue_full;
    logic         tx_queue_full;
    logic         rx_queue_empty;
    logic         transmit_in_progress;
  } iss_flags_type;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_AACK,
    I2C_WRITE,
    I2C_WACK,
    I2C_READ,
    I2C_RACK
  } iss_i2c_state_type;

endpackage
`default_nettype wire

// >>> hdl/iss_fifo.sv
// byte fifo with live fill count, empty and full
`default_nettype none
`include "iss_params.svh"
module iss_fifo (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           resetn,
  // fill side
  input  wire logic           push,
  input  wire iss_pkg::iss_byte_type push_data,
  // drain side
  input  wire logic           pop,
  output iss_pkg::iss_byte_type head,
  // state
  output iss_pkg::iss_fill_type count,
  output logic                empty,
  output logic                full
);
  import iss_pkg::*;

  iss_byte_type              mem_q [`ISS_FIFO_DEPTH];
  logic [`ISS_PTR_W-1:0]     wr_ptr_q;
  logic [`ISS_PTR_W-1:0]     rd_ptr_q;
  iss_fill_type              count_q;
  wire logic                 push_ok;
  wire logic                 pop_ok;

  // pushes to a full and pops from an empty fifo are dropped
  assign push_ok = push & ~full;
  assign pop_ok  = pop & ~empty;
  assign head    = mem_q[rd_ptr_q];
  assign count   = count_q;
  // flags come straight from the count, so they move on the same edge
  assign empty   = (count_q == '0); // R12 R15 R20
  assign full    = (count_q == `ISS_FILL_W'(`ISS_FIFO_DEPTH)); // R13 R14 R20

  always_ff @(posedge core_clk) begin
    if (push_ok) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + `ISS_PTR_W'(push_ok);
      rd_ptr_q <= rd_ptr_q + `ISS_PTR_W'(pop_ok);
      count_q  <= count_q + `ISS_FILL_W'(push_ok) - `ISS_FILL_W'(pop_ok);
    end
  end

endmodule
`default_nettype wire

// >>> hdl/iss_top.sv
// i2c/spi slave: control, flags, fifo thresholds and link engines
//
// Operation
// R01: control-byte enable makes first written i2c character the host control
// R02: status-byte enable sends status byte as first i2c read character
// R03: address bit 6 from host requests the same framing as enables
// R04: control holds spi clock polarity and phase, used only for spi
// R05: control bit 2 enables i2c operation
// R06: control bit 1 enables spi operation
// R07: control bit 0 enables whole slave; control resets to zero
// R08: flag bits 15:11 show receive fifo fill count
// R09: flag bits 10:6 show transmit fifo fill count
// R10: flag bit 5 high while a receive is in progress
// R11: flag bit 0 high while a transmit is in progress
// R12: flag bit 4 high when transmit fifo empty, resets high
// R13: flag bit 3 high when receive fifo full, resets low
// R14: flag bit 2 high when transmit fifo full, resets low
// R15: flag bit 1 high when receive fifo empty, resets high
// R16: receive threshold codes 000..100 fire at 1/8..7/8 full
// R17: transmit threshold codes 000..100 fire at 1/8..7/8 fill
// R18: programmable-level fields unsupported, writes ignored, read zero
// R19: data write pushes transmit fifo, data read pops receive fifo
// R20: level and flags follow occupancy on the edge of push or pop
//
// Added by the designer: the strobed register port and the address map.
`default_nettype none
`include "iss_params.svh"
module iss_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // i2c pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // spi pins
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // fifo level events
  output logic             rx_level_irq,
  output logic             tx_level_irq,
  // live flag word
  output iss_pkg::iss_flags_type flag_state
);
  import iss_pkg::*;

  // threshold code to fill count; msb marks a usable code
  function automatic logic [5:0] thr_fill(input logic [2:0] code);
    case (code)
      `ISS_THR_CODE_8TH: thr_fill = {1'b1, `ISS_THR_FILL_8TH};
      `ISS_THR_CODE_4TH: thr_fill = {1'b1, `ISS_THR_FILL_4TH};
      `ISS_THR_CODE_HALF: thr_fill = {1'b1, `ISS_THR_FILL_HALF};
      `ISS_THR_CODE_3QTR: thr_fill = {1'b1, `ISS_THR_FILL_3QTR};
      `ISS_THR_CODE_7TH: thr_fill = {1'b1, `ISS_THR_FILL_7TH};
      default: thr_fill = 6'h00;
    endcase
  endfunction

  // registers
  iss_ctrl_type         ctrl_q;
  logic [2:0]           rx_thr_q;
  logic [2:0]           tx_thr_q;
  logic [6:0]           own_addr_q;
  logic [3:0]           sw_status_q;
  iss_byte_type         host_ctrl_q;
  logic [31:0]          rdata_q;
  logic                 rx_irq_q;
  logic                 tx_irq_q;

  // pin synchronisers: scl, sda, sclk, cs_n, mosi
  logic [4:0]           sync1_q;
  logic [4:0]           sync2_q;
  logic [4:0]           prev_q;

  // fifo wires
  iss_byte_type         rx_head;
  iss_byte_type         tx_head;
  iss_fill_type         rx_count;
  iss_fill_type         tx_count;
  wire logic            rx_empty;
  wire logic            rx_full;
  wire logic            tx_empty;
  wire logic            tx_full;
  wire logic            rx_push;
  iss_byte_type         rx_push_data;
  wire logic            rx_pop;
  wire logic            tx_push;
  wire logic            tx_pop;

  // register decode
  wire logic            sel_data;
  wire logic            sel_ctrl;
  wire logic            sel_flags;
  wire logic            sel_fifo_irq_level_select;
  wire logic            sel_addr;
  wire logic            sel_stat;
  wire logic            sel_hctl;
  logic [31:0]          rd_mux;

  assign sel_data  = (reg_addr == `ISS_OFS_DATA);
  assign sel_ctrl  = (reg_addr == `ISS_OFS_CONTROL);
  assign sel_flags = (reg_addr == `ISS_OFS_FLAGS);
  assign sel_fifo_irq_level_select  = (reg_addr == `ISS_OFS_IRQ_LEVEL);
  assign sel_addr  = (reg_addr == `ISS_OFS_OWN_ADDR);
  assign sel_stat  = (reg_addr == `ISS_OFS_SW_STATUS);
  assign sel_hctl  = (reg_addr == `ISS_OFS_HOST_CTRL);

  assign tx_push = reg_wr & sel_data; // R19
  assign rx_pop  = reg_rd & sel_data; // R19

  // mode gating
  wire logic            i2c_on;
  wire logic            spi_on;
  assign i2c_on = ctrl_q.device_enable & ctrl_q.i2c_mode_enable; // R05 R07
  assign spi_on = ctrl_q.device_enable & ctrl_q.spi_mode_enable; // R06 R07

  // synchronised pin views; only sync2/prev are read
  wire logic            scl_s;
  wire logic            sda_s;
  wire logic            scl_p;
  wire logic            sda_p;
  wire logic            sclk_s;
  wire logic            sclk_p;
  wire logic            cs_n_s;
  wire logic            cs_n_p;
  wire logic            mosi_s;
  assign {scl_s, sda_s, sclk_s, cs_n_s, mosi_s} = sync2_q;
  assign {scl_p, sda_p, sclk_p, cs_n_p} = prev_q[4:1];

  // ---------------- i2c engine ----------------
  iss_i2c_state_type    state_q;
  iss_i2c_state_type    state_d;
  iss_byte_type         shift_q;
  iss_byte_type         shift_d;
  logic [3:0]           bitcnt_q;
  logic [3:0]           bitcnt_d;
  logic                 rw_q;
  logic                 rw_d;
  logic                 match_q;
  logic                 match_d;
  logic                 req_q;
  logic                 req_d;
  logic                 first_q;
  logic                 first_d;
  logic                 sda_oe_q;
  logic                 sda_oe_d;
  logic                 i2c_push;
  logic                 i2c_pop;
  logic                 hctl_load;

  wire logic            scl_rise;
  wire logic            scl_fall;
  wire logic            i2c_start;
  wire logic            i2c_stop;
  iss_byte_type         byte_in;
  iss_byte_type         status_byte;
  iss_byte_type         tx_pick;
  iss_byte_type         rd_byte;
  wire logic            frame_wr;
  wire logic            frame_rd;
  wire logic            send_status;

  assign scl_rise    = scl_s & ~scl_p;
  assign scl_fall    = ~scl_s & scl_p;
  assign i2c_start   = scl_s & scl_p & sda_p & ~sda_s;
  assign i2c_stop    = scl_s & scl_p & ~sda_p & sda_s;
  assign byte_in     = {shift_q[6:0], sda_s};
  assign frame_wr    = ctrl_q.host_control_byte_enable | req_q; // R01 R03
  assign frame_rd    = ctrl_q.host_status_byte_enable | req_q; // R02 R03
  assign status_byte = {tx_empty, rx_full, tx_full, rx_empty, sw_status_q};
  // a dry transmit fifo answers with the idle byte rather than stalling
  assign tx_pick     = tx_empty ? `ISS_IDLE_BYTE : tx_head;
  assign send_status = first_q & frame_rd; // R02
  assign rd_byte     = send_status ? status_byte : tx_pick;

  always_comb begin
    state_d   = state_q;
    shift_d   = shift_q;
    bitcnt_d  = bitcnt_q;
    rw_d      = rw_q;
    match_d   = match_q;
    req_d     = req_q;
    first_d   = first_q;
    sda_oe_d  = sda_oe_q;
    i2c_push  = 1'b0;
    i2c_pop   = 1'b0;
    hctl_load = 1'b0;
    if (!i2c_on || i2c_stop) begin
      state_d  = I2C_IDLE;
      sda_oe_d = 1'b0;
    end else if (i2c_start) begin
      state_d  = I2C_ADDR;
      bitcnt_d = '0;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        I2C_IDLE: begin
          sda_oe_d = 1'b0;
        end
        I2C_ADDR: begin
          if (scl_rise) begin
            shift_d  = byte_in;
            bitcnt_d = bitcnt_q + 4'h1;
            if (bitcnt_q == `ISS_LAST_BIT) begin
              rw_d    = sda_s;
              match_d = (byte_in[6:1] == own_addr_q[5:0]);
              req_d   = byte_in[7]; // R03
            end
          end else if (scl_fall && bitcnt_q == `ISS_BITS_PER_BYTE) begin
            bitcnt_d = '0;
            first_d  = 1'b1;
            if (match_q) begin
              state_d  = I2C_AACK;
              sda_oe_d = 1'b1;
            end else begin
              state_d = I2C_IDLE;
            end
          end
        end
        I2C_AACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              state_d  = I2C_READ;
              shift_d  = rd_byte;
              sda_oe_d = ~rd_byte[7];
              i2c_pop  = ~send_status;
              first_d  = 1'b0;
            end else begin
              state_d  = I2C_WRITE;
              sda_oe_d = 1'b0;
            end
          end
        end
        I2C_WRITE: begin
          if (scl_rise) begin
            shift_d  = byte_in;
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == `ISS_BITS_PER_BYTE) begin
            hctl_load = first_q & frame_wr; // R01
            i2c_push  = ~(first_q & frame_wr);
            first_d   = 1'b0;
            bitcnt_d  = '0;
            state_d   = I2C_WACK;
            sda_oe_d  = 1'b1;
          end
        end
        I2C_WACK: begin
          if (scl_fall) begin
            state_d  = I2C_WRITE;
            sda_oe_d = 1'b0;
          end
        end
        I2C_READ: begin
          if (scl_rise) begin
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_q == `ISS_BITS_PER_BYTE) begin
              state_d  = I2C_RACK;
              sda_oe_d = 1'b0;
              bitcnt_d = '0;
            end else begin
              shift_d  = {shift_q[6:0], 1'b0};
              sda_oe_d = ~shift_q[6];
            end
          end
        end
        I2C_RACK: begin
          if (scl_rise && sda_s) begin
            state_d = I2C_IDLE;
          end else if (scl_fall) begin
            state_d  = I2C_READ;
            shift_d  = tx_pick;
            sda_oe_d = ~tx_pick[7];
            i2c_pop  = 1'b1;
          end
        end
        default: begin
          state_d  = I2C_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  // ---------------- spi engine ----------------
  iss_byte_type         spi_in_q;
  iss_byte_type         spi_out_q;
  logic [2:0]           spi_cnt_q;
  logic                 miso_q;
  wire logic            spi_sel;
  wire logic            sclk_rise;
  wire logic            sclk_fall;
  wire logic            lead_edge;
  wire logic            trail_edge;
  wire logic            sample_edge;
  wire logic            shift_edge;
  wire logic            spi_load;
  wire logic            spi_done;

  assign spi_sel     = spi_on & ~cs_n_s;
  assign sclk_rise   = sclk_s & ~sclk_p;
  assign sclk_fall   = ~sclk_s & sclk_p;
  // idle level of sclk sets which edge leads
  assign lead_edge   = ctrl_q.spi_clk_polarity ? sclk_fall : sclk_rise; // R04
  assign trail_edge  = ctrl_q.spi_clk_polarity ? sclk_rise : sclk_fall;
  assign sample_edge = ctrl_q.spi_clk_phase ? trail_edge : lead_edge; // R04
  assign shift_edge  = ctrl_q.spi_clk_phase ? lead_edge : trail_edge;
  // phase 0 must show its first bit before any edge, so load at select
  assign spi_load    = spi_sel & ((cs_n_p & ~ctrl_q.spi_clk_phase)
                     | (shift_edge & (spi_cnt_q == 3'h0)));
  assign spi_done    = spi_sel & sample_edge & (spi_cnt_q == 3'h7);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      spi_in_q  <= '0;
      spi_out_q <= '0;
      spi_cnt_q <= '0;
      miso_q    <= 1'b0;
    end else if (!spi_sel) begin
      spi_cnt_q <= '0;
    end else begin
      if (sample_edge) begin
        spi_in_q  <= {spi_in_q[6:0], mosi_s};
        spi_cnt_q <= spi_cnt_q + 3'h1;
      end
      if (spi_load) begin
        spi_out_q <= tx_pick;
        miso_q    <= tx_pick[7];
      end else if (shift_edge) begin
        spi_out_q <= {spi_out_q[6:0], 1'b0};
        miso_q    <= spi_out_q[6];
      end
    end
  end

  // ---------------- fifos and flags ----------------
  assign rx_push      = i2c_push | spi_done;
  assign rx_push_data = i2c_push ? shift_q : {spi_in_q[6:0], mosi_s};
  assign tx_pop       = i2c_pop | (spi_load & ~tx_empty);

  iss_fifo u_rx_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .push      (rx_push),
    .push_data (rx_push_data),
    .pop       (rx_pop),
    .head      (rx_head),
    .count     (rx_count),
    .empty     (rx_empty),
    .full      (rx_full)
  );

  iss_fifo u_tx_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .push      (tx_push),
    .push_data (reg_wdata[7:0]),
    .pop       (tx_pop),
    .head      (tx_head),
    .count     (tx_count),
    .empty     (tx_empty),
    .full      (tx_full)
  );

  wire logic [5:0]      rx_thr;
  wire logic [5:0]      tx_thr;
  assign rx_thr = thr_fill(rx_thr_q);
  assign tx_thr = thr_fill(tx_thr_q);

  assign flag_state.rx_fill_count        = rx_count; // R08
  assign flag_state.tx_fill_count        = tx_count; // R09
  assign flag_state.receive_in_progress  = (state_q == I2C_WRITE)
    | (state_q == I2C_WACK) | spi_sel; // R10
  assign flag_state.tx_queue_empty       = tx_empty; // R12
  assign flag_state.rx_queue_full        = rx_full; // R13
  assign flag_state.tx_queue_full        = tx_full; // R14
  assign flag_state.rx_queue_empty       = rx_empty; // R15
  assign flag_state.transmit_in_progress = (state_q == I2C_READ)
    | (state_q == I2C_RACK) | spi_sel; // R11

  // programmable-level fields read as zero
  assign rd_mux = sel_data  ? {24'h0, rx_head} :
                  sel_ctrl  ? {25'h0, ctrl_q} :
                  sel_flags ? {16'h0, flag_state} :
                  sel_fifo_irq_level_select  ? {26'h0, rx_thr_q, tx_thr_q} : // R18
                  sel_addr  ? {25'h0, own_addr_q} :
                  sel_stat  ? {28'h0, sw_status_q} :
                  sel_hctl  ? {24'h0, host_ctrl_q} : 32'h0;

  assign reg_rdata    = rdata_q;
  assign sda_out      = 1'b0;
  assign sda_oe       = sda_oe_q;
  assign spi_miso     = miso_q;
  assign spi_miso_oe  = spi_sel;
  assign rx_level_irq = rx_irq_q;
  assign tx_level_irq = tx_irq_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= `ISS_SYNC_RESET;
      sync2_q <= `ISS_SYNC_RESET;
      prev_q  <= `ISS_SYNC_RESET;
    end else begin
      sync1_q <= {scl_in, sda_in, spi_sclk, spi_cs_n, spi_mosi};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= I2C_IDLE;
      shift_q  <= '0;
      bitcnt_q <= '0;
      rw_q     <= 1'b0;
      match_q  <= 1'b0;
      req_q    <= 1'b0;
      first_q  <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      shift_q  <= shift_d;
      bitcnt_q <= bitcnt_d;
      rw_q     <= rw_d;
      match_q  <= match_d;
      req_q    <= req_d;
      first_q  <= first_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q      <= `ISS_CONTROL_RESET; // R07
      rx_thr_q    <= `ISS_THR_RESET;
      tx_thr_q    <= `ISS_THR_RESET;
      own_addr_q  <= `ISS_OWN_ADDR_RESET;
      sw_status_q <= `ISS_SW_STAT_RESET;
      rdata_q     <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
      if (reg_wr && sel_ctrl) begin
        ctrl_q <= iss_ctrl_type'(reg_wdata[6:0]); // R04
      end
      if (reg_wr && sel_fifo_irq_level_select) begin
        rx_thr_q <= reg_wdata[5:3]; // R16
        tx_thr_q <= reg_wdata[2:0]; // R17
      end
      if (reg_wr && sel_addr) begin
        own_addr_q <= reg_wdata[6:0];
      end
      if (reg_wr && sel_stat) begin
        sw_status_q <= reg_wdata[3:0];
      end
    end
  end

  // host control byte is written only from the link side
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_ctrl_q <= `ISS_HOST_CTL_RESET;
      rx_irq_q    <= 1'b0;
      tx_irq_q    <= 1'b0;
    end else begin
      if (hctl_load) begin
        host_ctrl_q <= shift_q; // R01
      end
      rx_irq_q <= rx_thr[5] & (rx_count >= rx_thr[4:0]); // R16
      tx_irq_q <= tx_thr[5] & (tx_count <= tx_thr[4:0]); // R17
    end
  end

endmodule
`default_nettype wire

// >>> verif/iss_top_asserts.sv
// port assertions for the i2c/spi slave block
`default_nettype none
module iss_top_asserts (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // spi select
  input wire logic        spi_cs_n,
  input wire logic        spi_miso_oe,
  // flag word
  input wire iss_pkg::iss_flags_type flag_state
);
  timeunit 1ns;
  timeprecision 1ns;
  import iss_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // link traffic excluded except the i2c pop in I2C_AACK: a serial push or pop may land on the same edge
  sequence s_data_wr;
    reg_wr && reg_addr == 8'h00 && !flag_state.tx_queue_full
      && !flag_state.transmit_in_progress;
  endsequence
  sequence s_data_rd;
    reg_rd && reg_addr == 8'h00 && !flag_state.rx_queue_empty
      && !flag_state.receive_in_progress;
  endsequence
  a_tx_empty_flag: assert property (
    flag_state.tx_queue_empty == (flag_state.tx_fill_count == 5'h00))
    else $error("tx empty flag wrong");
  a_rx_empty_flag: assert property (
    flag_state.rx_queue_empty == (flag_state.rx_fill_count == 5'h00))
    else $error("rx empty flag wrong");
  a_tx_full_flag: assert property (
    flag_state.tx_queue_full == (flag_state.tx_fill_count == 5'h10))
    else $error("tx full flag wrong");
  a_rx_full_flag: assert property (
    flag_state.rx_queue_full == (flag_state.rx_fill_count == 5'h10))
    else $error("rx full flag wrong");
  a_data_push: assert property (s_data_wr |=>
    flag_state.tx_fill_count == $past(flag_state.tx_fill_count) + 5'h01)
    else $error("data write did not push");
  a_data_pop: assert property (s_data_rd |=>
    flag_state.rx_fill_count == $past(flag_state.rx_fill_count) - 5'h01)
    else $error("data read did not pop");
  a_flag_read: assert property (reg_rd && reg_addr == 8'h08 |=>
    reg_rdata[15:0] == $past(flag_state))
    else $error("flag read differs from live flags");
  a_miso_idle: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule
bind iss_top iss_top_asserts iss_top_asserts_inst (.core_clk, .resetn,
  .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .spi_cs_n, .spi_miso_oe,
  .flag_state);
`default_nettype wire

// >>> verif/iss_spi_host.sv
// spi and i2c master model facing the slave's serial pins
`default_nettype none
module iss_spi_host (
  // serial pins
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  output logic      i2c_scl,
  output logic      i2c_sda,
  input  wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    i2c_scl = 1'b1;
    i2c_sda = 1'b1;
  end
  // m picks mode 3 over mode 0; sclk idles 80 ns before select
  task automatic xfer(input logic m, input logic [7:0] tx,
    output logic [7:0] rx);
    spi_sclk = m;
    #80 spi_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!m) spi_mosi = tx[i];
      #80 spi_sclk = ~m;
      if (m) spi_mosi = tx[i];
      rx[i] = spi_miso;
      #80 spi_sclk = m;
      if (m) rx[i] = spi_miso;
    end
    #80 spi_cs_n = 1'b1;
    // released line must not keep its last value
    spi_mosi = ~spi_mosi;
  endtask
  // ack slots go out as 1 so the slave can pull the line low
  task automatic i2c_wr(input logic [17:0] s);
    #80 i2c_sda = 1'b0;
    for (int i = 17; i >= -1; i--) begin
      #80 i2c_scl = 1'b0;
      #40 i2c_sda = i >= 0 && s[i];
      #40 i2c_scl = 1'b1;
    end
    #80 i2c_sda = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> verif/test_iss_top.sv
// self-checking bench for the i2c/spi slave block
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH %0t %s", $time, m); end end
module test_iss_top;
  timeunit 1ns;
  timeprecision 1ns;
  import iss_pkg::*;
  logic          core_clk = 1'b0;
  logic          resetn = 1'b0;
  logic [7:0]    reg_addr = 8'h00;
  logic [31:0]   reg_wdata = 32'h0;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [31:0]   reg_rdata, rd_q;
  logic          spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic          i2c_scl, i2c_sda, sda_out, sda_oe;
  logic          rx_level_irq, tx_level_irq;
  iss_flags_type flag_state;
  int            fail_count = 0;
  int            total_checks = 0;
  initial forever #4 core_clk = ~core_clk;
  // open-drain sda: low while either side pulls it
  iss_top iss_top_inst (.core_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .scl_in(i2c_scl),
    .sda_in(i2c_sda & (~sda_oe | sda_out)), .sda_out, .sda_oe,
    .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe, .rx_level_irq, .tx_level_irq, .flag_state);
  iss_spi_host iss_spi_host_inst (.spi_sclk, .spi_cs_n, .spi_mosi,
    .i2c_scl, .i2c_sda, .spi_miso);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  task automatic t_reset();
    rd(8'h04);
    `CHK(rd_q, 32'h0, "control reset")
    rd(8'h08);
    `CHK(rd_q[15:0], 16'h0012, "flags reset")
    rd(8'h40);
    `CHK(rd_q, 32'h0, "unmapped read")
  endtask
  task automatic t_ctrl();
    for (int i = 0; i < 7; i++) begin
      wr(8'h04, 32'h1 << i);
      rd(8'h04);
      `CHK(rd_q[6:0], 7'h01 << i, "control bit")
    end
  endtask
  task automatic t_tx_fill();
    wr(8'h0c, 32'h0000_0009);
    rd(8'h0c);
    `CHK(rd_q[11:0], 12'h009, "level select")
    // the 17th byte meets a full queue and is dropped
    for (int n = 1; n <= 17; n++) begin
      wr(8'h00, 32'h10 + n);
      repeat (3) @(negedge core_clk);
      `CHK(flag_state.tx_fill_count, 5'(n > 16 ? 16 : n), "tx fill")
      `CHK(flag_state.tx_queue_full, 1'(n >= 16), "tx full")
      `CHK(flag_state.tx_queue_empty, 1'b0, "tx empty")
      `CHK(tx_level_irq, 1'(n <= 4), "tx level event")
    end
  endtask
  task automatic t_spi();
    logic [7:0] got;
    wr(8'h04, 32'h0000_0002);
    iss_spi_host_inst.xfer(1'b0, 8'h5a, got);
    repeat (4) @(negedge core_clk);
    `CHK(flag_state.rx_fill_count, 5'h00, "taken while disabled")
    for (int k = 0; k < 3; k++) begin
      wr(8'h04, k == 2 ? 32'h1b : 32'h3);
      fork
        iss_spi_host_inst.xfer(k == 2, 8'(8'ha0 + k), got);
        begin
          repeat (40) @(negedge core_clk);
          `CHK(flag_state.receive_in_progress, 1'b1, "rx busy")
          `CHK(flag_state.transmit_in_progress, 1'b1, "tx busy")
          `CHK(spi_miso_oe, 1'b1, "miso drive")
        end
      join
      `CHK(got, 8'(8'h11 + 2 * k), "byte out")
    end
    repeat (4) @(negedge core_clk);
    `CHK(flag_state.receive_in_progress, 1'b0, "rx idle")
    `CHK(flag_state.transmit_in_progress, 1'b0, "tx idle")
    rd(8'h08);
    `CHK(rd_q[15:11], 5'h03, "rx fill")
    // fill of 3 reaches only the 1/8 mark; codes above 100 never fire
    for (int c = 0; c < 8; c++) begin
      wr(8'h0c, 32'(c * 9));
      repeat (3) @(negedge core_clk);
      `CHK(rx_level_irq, 1'(c == 0), "rx level event")
    end
    for (int k = 0; k < 4; k++) begin
      rd(8'h00);
      if (k < 3) `CHK(rd_q[7:0], 8'(8'ha0 + k), "rx byte")
    end
    `CHK(flag_state.rx_queue_empty, 1'b1, "rx empty")
    `CHK(flag_state.rx_fill_count, 5'h00, "rx drained")
  endtask
  task automatic t_i2c();
    wr(8'h04, 32'h0000_0005);
    iss_spi_host_inst.i2c_wr({8'h80, 1'b1, 8'h96, 1'b1});
    rd(8'h18);
    `CHK(rd_q[7:0], 8'h96, "host control byte")
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_tx_fill();
    t_spi();
    t_i2c();
    results();
  end
  // the whole sequence needs about 11 us
  initial begin
    #100000;
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
